/* pkg/regflags_pkg.sv */
package regflags_pkg;

    // register byte addresses on the internal register port
    localparam logic [7:0] ADDR_SOFTWARE_RESET_BIT   = 8'h18;
    localparam logic [7:0] ADDR_TOP_FIRST  = 8'h19;
    localparam logic [7:0] ADDR_TOP_SECOND = 8'h1a;
    localparam logic [7:0] ADDR_BUCK       = 8'h1b;
    localparam logic [7:0] ADDR_LINEAR     = 8'h1c;
    localparam logic [7:0] ADDR_LIVE       = 8'h1d;

    // top_flags_first field positions
    localparam int TOP_PG_DROP  = 7;
    localparam int TOP_LIN_SUM  = 6;
    localparam int TOP_BUCK_SUM = 5;
    localparam int TOP_EXT_CLK  = 4;
    localparam int TOP_TSD      = 3;
    localparam int TOP_TWARN    = 2;
    localparam int TOP_OVP      = 1;
    localparam int TOP_MEAS     = 0;

    // top_flags_second, software reset and live status positions
    localparam int SECOND_RESET  = 0;
    localparam int SWRST_BIT     = 0;
    localparam int LIVE_PG       = 7;
    localparam int LIVE_EXT_CLK  = 4;
    localparam int LIVE_TSD      = 3;
    localparam int LIVE_TWARN    = 2;
    localparam int LIVE_OVP      = 1;

    // per-regulator group: channel 1 sits one nibble above channel 0
    localparam int GRP_PG     = 2;
    localparam int GRP_SC     = 1;
    localparam int GRP_ILIM   = 0;
    localparam int GRP_STRIDE = 4;

    // writable-flag masks and reset values
    localparam logic [7:0] TOP_FIRST_MASK  = 8'h9f;
    localparam logic [7:0] TOP_SECOND_MASK = 8'h01;
    localparam logic [7:0] GROUP_MASK      = 8'h77;
    localparam logic [7:0] FLAGS_RESET     = 8'h00;

    // short-circuit qualification time
    localparam int unsigned SHORT_TIME_NS = 1000000;
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned SHORT_CYCLES  = SHORT_TIME_NS / CLK_PERIOD_NS;

    // number of regulators with per-channel flags (two buck, two linear)
    localparam int NUM_CH = 4;

    typedef enum logic [1:0] {RST_IDLE, RST_RESTORE, RST_STARTUP} reset_state_t;

    // write-one-to-clear update; a set in the same cycle wins over the clear
    function automatic logic [7:0] w1c_next(input logic [7:0] cur,
                                            input logic [7:0] set,
                                            input logic       hit,
                                            input logic [7:0] wdata,
                                            input logic [7:0] mask);
        logic [7:0] clr;
        clr = hit ? wdata : 8'h00;
        return ((cur & ~clr) | set) & mask;
    endfunction

endpackage

/* hw/short_debounce.sv */
`timescale 1ns/100ps
module short_debounce
#(
    parameter int unsigned CYCLES = 200000,
    parameter int          CW     = $clog2(CYCLES + 1)
)
(
    // clock, reset, enable
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic ce,
    // control and sense
    input  wire logic restore,
    input  wire logic below,
    // qualified result
    output logic      long_low
);
    logic [CW-1:0] cnt;

    // counts cycles spent below threshold, saturating at the limit
    always_ff @(posedge clk)
    begin
        if (!nrst)
            cnt <= '0;
        else if (ce)
        begin
            if (!below || restore)
                cnt <= '0;
            else if (cnt != CW'(CYCLES))
                cnt <= cnt + CW'(1);
        end
    end

    // only a low lasting past the full count qualifies
    always_ff @(posedge clk)
    begin
        if (!nrst)
            long_low <= 1'b0;
        else if (ce)
            long_low <= below && !restore && (cnt == CW'(CYCLES)); // R13
    end

    AST_SC_LONG: assert property (@(posedge clk) disable iff (!nrst)
        $rose(long_low) |-> $past(below) && $past(cnt) == CW'(CYCLES)) // R13
        else $error("short flagged before the low lasted long enough");

endmodule // short_debounce

/* hw/regulator_event_flags.sv */
// Behaviour
// [R1] Power-good output going active to inactive latches top bit 7.
// [R2] Top bit 6 reads set while linear flags are nonzero, clears itself.
// [R3] Top bit 5 reads set while buck flags are nonzero, clears itself.
// [R4] External clock appearing or disappearing latches top bit 4.
// [R5] Thermal shutdown latches bit 3, disables regulators, drives outputs low.
// [R6] Regulators cannot be enabled while the thermal shutdown flag is set.
// [R7] Latched thermal flags stay separate from live status bits.
// [R8] Thermal warning latches bit 2 and leaves regulators running.
// [R9] Input overvoltage latches bit 1, disables regulators, drives outputs low.
// [R10] A ready load-current result latches top bit 0.
// [R11] Undervoltage or software reset restores defaults, restarts, then sets reset flag.
// [R12] Buck power-good events latch bit 6 (one) and bit 2 (zero).
// [R13] Buck short flags bits 5 and 1 need output low over 1 ms.
// [R14] Buck current-limit activity latches bit 4 (one) and bit 0 (zero).
// [R15] Host clears a flag by writing one; all flags reset to zero.
// [R16] Software reset bit restores registers, resets serial interface, clears itself.
// [R17] Linear flag register holds per-regulator power-good, short, limit flags.
// [R18] Flags persist after the cause; a same-cycle event beats the clear.
`timescale 1ns/100ps
module regulator_event_flags
#(
    parameter int unsigned SHORT_CNT = regflags_pkg::SHORT_CYCLES
)
(
    // clock, reset, enable
    input  wire logic                        clk,
    input  wire logic                        nrst,
    input  wire logic                        ce,
    // internal register port of the serial interface
    input  wire logic [7:0]                  reg_addr,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    input  wire logic [7:0]                  reg_wdata,
    output logic      [7:0]                  reg_rdata,
    // analog monitors and pins, asynchronous
    input  wire logic                        power_good_output,
    input  wire logic                        ext_clk_valid,
    input  wire logic                        thermal_shutdown_in,
    input  wire logic                        thermal_warning_in,
    input  wire logic                        overvoltage_in,
    input  wire logic                        analog_supply_low,
    input  wire logic [regflags_pkg::NUM_CH-1:0] pg_invalid,
    input  wire logic [regflags_pkg::NUM_CH-1:0] below_short,
    input  wire logic [regflags_pkg::NUM_CH-1:0] ilim_active,
    // same-clock requests
    input  wire logic                        meas_done,
    input  wire logic                        startup_done,
    input  wire logic [regflags_pkg::NUM_CH-1:0] enable_req,
    input  wire logic                        gpo_a_req,
    input  wire logic                        gpo_b_req,
    // regulator and output control
    output logic      [regflags_pkg::NUM_CH-1:0] regulator_enable,
    output logic                             general_output_a,
    output logic                             general_output_b,
    output logic                             defaults_restore,
    output logic                             serial_reset,
    output logic                             startup_start
);
    import regflags_pkg::*;
    localparam int SYNC_W = 6 + 3 * NUM_CH;
    localparam int EDGE_W = 6 + NUM_CH;

    logic [SYNC_W-1:0] sync_q1;
    logic [SYNC_W-1:0] sync_q2;
    logic [EDGE_W-1:0] edge_prev;
    logic              pg_now, ext_now, tsd_now, twarn_now, ovp_now, uv_now;
    logic              pg_was, ext_was, tsd_was, twarn_was, ovp_was, uv_was;
    logic [NUM_CH-1:0] pginv_now, pginv_was, below_now, ilim_now, sc_long;
    logic [7:0]        top_first;
    logic [7:0]        top_second;
    logic [7:0]        buck_flags;
    logic [7:0]        linear_flags;
    logic [7:0]        next_top_first, next_top_second, next_buck, next_linear;
    logic [7:0]        top_set, buck_set, linear_set, top_first_view, live_view;
    logic              software_reset_bit;
    logic              pg_drop, ext_change, tsd_rise, twarn_rise, ovp_rise, uv_rise;
    logic [NUM_CH-1:0] pg_event;
    logic              in_restore, kill_regs, software_reset_bit_wr;
    reset_state_t      rst_state;

    // two-stage synchroniser for everything arriving from the analog side
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            sync_q1 <= '0;
            sync_q2 <= '0;
        end
        else if (ce)
        begin
            sync_q1 <= {power_good_output, ext_clk_valid, thermal_shutdown_in,
                        thermal_warning_in, overvoltage_in, analog_supply_low,
                        pg_invalid, below_short, ilim_active};
            sync_q2 <= sync_q1;
        end
    end

    assign {pg_now, ext_now, tsd_now, twarn_now, ovp_now, uv_now,
            pginv_now, below_now, ilim_now} = sync_q2;

    // previous synchronised levels for edge detection
    always_ff @(posedge clk)
    begin
        if (!nrst)
            edge_prev <= '0;
        else if (ce)
            edge_prev <= {pg_now, ext_now, tsd_now, twarn_now, ovp_now, uv_now, pginv_now};
    end

    assign {pg_was, ext_was, tsd_was, twarn_was, ovp_was, uv_was, pginv_was} = edge_prev;

    // event detection from the synchronised levels
    assign pg_drop    = pg_was && !pg_now;  // R1
    assign ext_change = ext_was ^ ext_now;  // R4
    assign tsd_rise   = tsd_now && !tsd_was;
    assign twarn_rise = twarn_now && !twarn_was;
    assign ovp_rise   = ovp_now && !ovp_was;
    assign uv_rise    = uv_now && !uv_was;
    assign pg_event   = pginv_now & ~pginv_was; // R12

    // one qualification timer per regulator output
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++)
        begin : g_short
            short_debounce #(
                .CYCLES (SHORT_CNT)
            ) u_short (
                .clk      (clk),
                .nrst     (nrst),
                .ce       (ce),
                .restore  (in_restore),
                .below    (below_now[ch]),
                .long_low (sc_long[ch])
            );
        end
    endgenerate

    // set vectors; channels 0,1 are the bucks, 2,3 the linear regulators
    assign top_set = {pg_drop, 2'b00, ext_change, tsd_rise, twarn_rise, ovp_rise,
                      meas_done}; // R1 R4 R5 R8 R9 R10
    assign buck_set = {1'b0, pg_event[1], sc_long[1], ilim_now[1],
                       1'b0, pg_event[0], sc_long[0], ilim_now[0]}; // R12 R13 R14
    assign linear_set = {1'b0, pg_event[3], sc_long[3], ilim_now[3],
                         1'b0, pg_event[2], sc_long[2], ilim_now[2]}; // R17

    assign in_restore  = (rst_state == RST_RESTORE);
    assign software_reset_bit_wr = reg_wr && reg_addr == ADDR_SOFTWARE_RESET_BIT && reg_wdata[SWRST_BIT];

    // next flag values: write-one clears, a simultaneous event wins
    always_comb
    begin
        next_top_first  = w1c_next(top_first, top_set,
                                   reg_wr && reg_addr == ADDR_TOP_FIRST,
                                   reg_wdata, TOP_FIRST_MASK); // R15 R18
        next_buck       = w1c_next(buck_flags, buck_set,
                                   reg_wr && reg_addr == ADDR_BUCK,
                                   reg_wdata, GROUP_MASK); // R15 R18
        next_linear     = w1c_next(linear_flags, linear_set,
                                   reg_wr && reg_addr == ADDR_LINEAR,
                                   reg_wdata, GROUP_MASK); // R17
        next_top_second = w1c_next(top_second,
                                   {7'h00, rst_state == RST_STARTUP && startup_done},
                                   reg_wr && reg_addr == ADDR_TOP_SECOND,
                                   reg_wdata, TOP_SECOND_MASK); // R11 R15
    end

    // flag registers; restore wipes them back to defaults
    always_ff @(posedge clk)
    begin
        if (!nrst || (ce && in_restore))
        begin
            top_first    <= FLAGS_RESET; // R15
            top_second   <= FLAGS_RESET;
            buck_flags   <= FLAGS_RESET;
            linear_flags <= FLAGS_RESET;
        end
        else if (ce)
        begin
            top_first    <= next_top_first;
            top_second   <= next_top_second;
            buck_flags   <= next_buck;
            linear_flags <= next_linear;
        end
    end

    // reset sequencer; stays in restore while the supply is still low
    always_ff @(posedge clk)
    begin
        if (!nrst)
            rst_state <= RST_IDLE;
        else if (ce)
        begin
            case (rst_state)
                RST_IDLE:
                    if (uv_rise || software_reset_bit)
                        rst_state <= RST_RESTORE; // R11 R16
                RST_RESTORE:
                    if (!uv_now)
                        rst_state <= RST_STARTUP;
                RST_STARTUP:
                    if (startup_done)
                        rst_state <= RST_IDLE;
                default:
                    rst_state <= RST_IDLE;
            endcase
        end
    end

    // software reset bit is written by the host and drops once the restore starts
    always_ff @(posedge clk)
    begin
        if (!nrst)
            software_reset_bit <= 1'b0;
        else if (ce)
        begin
            if (in_restore)
                software_reset_bit <= 1'b0; // R16
            else if (software_reset_bit_wr)
                software_reset_bit <= 1'b1;
        end
    end

    // sequencer strobes: restore and serial reset on entry, startup on exit
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            defaults_restore <= 1'b0;
            serial_reset     <= 1'b0;
            startup_start    <= 1'b0;
        end
        else if (ce)
        begin
            defaults_restore <= (rst_state == RST_IDLE) && (uv_rise || software_reset_bit);
            serial_reset     <= (rst_state == RST_IDLE) && (uv_rise || software_reset_bit);
            startup_start    <= in_restore && !uv_now; // R11
        end
    end

    // regulators drop the cycle a fault latches; the flag then holds them off
    assign kill_regs = top_first[TOP_TSD] || tsd_rise || top_first[TOP_OVP] || ovp_rise
                       || rst_state != RST_IDLE; // R5 R6 R9 R11

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            regulator_enable <= '0;
            general_output_a <= 1'b0;
            general_output_b <= 1'b0;
        end
        else if (ce)
        begin
            regulator_enable <= kill_regs ? '0 : enable_req; // R6
            general_output_a <= gpo_a_req && !(top_first[TOP_TSD] || tsd_rise
                                || top_first[TOP_OVP] || ovp_rise); // R5 R9
            general_output_b <= gpo_b_req && !(top_first[TOP_TSD] || tsd_rise
                                || top_first[TOP_OVP] || ovp_rise);
        end
    end

    // summary bits are computed, never stored, so they clear by themselves
    assign top_first_view = {top_first[TOP_PG_DROP], |linear_flags, |buck_flags,
                             top_first[4:0]}; // R2 R3
    // live view reports present conditions, independent of the latches
    assign live_view = {pg_now, 2'b00, !ext_now, tsd_now, twarn_now, ovp_now, 1'b0}; // R7

    // registered read data; unmapped addresses read zero
    always_ff @(posedge clk)
    begin
        if (!nrst)
            reg_rdata <= 8'h00;
        else if (ce && reg_rd)
        begin
            case (reg_addr)
                ADDR_SOFTWARE_RESET_BIT:   reg_rdata <= {7'h00, software_reset_bit};
                ADDR_TOP_FIRST:  reg_rdata <= top_first_view;
                ADDR_TOP_SECOND: reg_rdata <= top_second;
                ADDR_BUCK:       reg_rdata <= buck_flags;
                ADDR_LINEAR:     reg_rdata <= linear_flags;
                ADDR_LIVE:       reg_rdata <= live_view;
                default:         reg_rdata <= 8'h00;
            endcase
        end
    end

    // checks on the latching and sequencing behaviour
    AST_PG_DROP: assert property (@(posedge clk) disable iff (!nrst) // R1
        ce && pg_drop && !in_restore |=> top_first[TOP_PG_DROP])
        else $error("power-good drop not latched");
    AST_LIN_SUM: assert property (@(posedge clk) disable iff (!nrst) // R2
        ce && reg_rd && reg_addr == ADDR_TOP_FIRST |=> reg_rdata[TOP_LIN_SUM] == $past(|linear_flags))
        else $error("linear summary does not follow linear flags");
    AST_BUCK_SUM: assert property (@(posedge clk) disable iff (!nrst) // R3
        ce && reg_rd && reg_addr == ADDR_TOP_FIRST |=> reg_rdata[TOP_BUCK_SUM] == $past(|buck_flags))
        else $error("buck summary does not follow buck flags");
    AST_EXT_CLK: assert property (@(posedge clk) disable iff (!nrst) // R4
        ce && !in_restore && $past(ext_now) != ext_now && ext_was != ext_now
        |=> top_first[TOP_EXT_CLK])
        else $error("external clock change not latched");
    AST_TSD_OFF: assert property (@(posedge clk) disable iff (!nrst) // R5
        ce && tsd_rise && !in_restore
        |=> top_first[TOP_TSD] && regulator_enable == '0 && !general_output_a && !general_output_b)
        else $error("thermal shutdown did not shut down");
    AST_TSD_REFUSE: assert property (@(posedge clk) disable iff (!nrst) // R6
        top_first[TOP_TSD] |-> regulator_enable == '0)
        else $error("regulator enabled under thermal shutdown flag");
    AST_TWARN_RUN: assert property (@(posedge clk) disable iff (!nrst) // R8
        ce && twarn_rise && !kill_regs |=> top_first[TOP_TWARN] && regulator_enable == $past(enable_req))
        else $error("thermal warning wrong");
    AST_OVP_OFF: assert property (@(posedge clk) disable iff (!nrst) // R9
        ce && ovp_rise && !in_restore |=> top_first[TOP_OVP] && regulator_enable == '0 ##1 !general_output_a || !ce)
        else $error("overvoltage did not shut down");
    AST_MEAS: assert property (@(posedge clk) disable iff (!nrst) // R10
        ce && meas_done && !in_restore |=> top_first[TOP_MEAS])
        else $error("measurement ready not latched");
    AST_RESET_FLAG: assert property (@(posedge clk) disable iff (!nrst) // R11
        ce && rst_state == RST_STARTUP && startup_done |=> top_second[SECOND_RESET] && rst_state == RST_IDLE)
        else $error("reset flag not set after startup");
    AST_SET_WINS: assert property (@(posedge clk) disable iff (!nrst) // R18
        ce && !in_restore && tsd_rise && reg_wr && reg_addr == ADDR_TOP_FIRST && reg_wdata[TOP_TSD]
        |=> top_first[TOP_TSD])
        else $error("clearing write beat a new event");
    AST_W1C: assert property (@(posedge clk) disable iff (!nrst) // R15
        ce && reg_wr && reg_addr == ADDR_BUCK && reg_wdata[GRP_ILIM] && !buck_set[GRP_ILIM]
        |=> !buck_flags[GRP_ILIM])
        else $error("write one did not clear flag");

    COV_TSD: cover property (@(posedge clk) disable iff (!nrst) ce && tsd_rise);
    COV_SOFTWARE_RESET_BIT: cover property (@(posedge clk) disable iff (!nrst)
        rst_state == RST_STARTUP && ce && startup_done);
    COV_SHORT: cover property (@(posedge clk) disable iff (!nrst) |sc_long);

endmodule // regulator_event_flags

/* testbench/host_model.sv */
`timescale 1ns/100ps
// host on the register port; one access at a time, held across its edge
module host_model
(
    // clock
    input  wire logic       clk,
    // register port
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    initial
    begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 8'h00;
    end
    // write one to clear: one strobe edge, data flipped on release
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(posedge clk);
        #1;
        reg_wr    = 1'b0;
        reg_wdata = ~d;
    endtask
    // read; data stands until next read, so take it one edge late
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd   = 1'b1;
        @(posedge clk);
        #1;
        reg_rd   = 1'b0;
        @(posedge clk);
        #1;
        d = reg_rdata;
    endtask
endmodule // host_model

/* testbench/regulator_event_flags_tb_top.sv */
`timescale 1ns/100ps
module regulator_event_flags_tb_top;
    import regflags_pkg::*;
    localparam int unsigned SC = 8;
    logic       clk, ce, nrst, reg_wr, reg_rd, power_good_output, ext_clk_valid;
    logic       thermal_shutdown_in, thermal_warning_in, overvoltage_in, analog_supply_low;
    logic       meas_done, startup_done, gpo_a_req, gpo_b_req, general_output_a;
    logic       general_output_b, defaults_restore, serial_reset, startup_start;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rdv;
    logic [3:0] pg_invalid, below_short, ilim_active, enable_req, regulator_enable;
    int         top, sec, buck, lin, n_fail, check_count, cyc, seed, b;

    regulator_event_flags #(.SHORT_CNT(SC)) DUT (.clk, .nrst, .ce, .reg_addr, .reg_wr,
        .reg_rd, .reg_wdata, .reg_rdata, .power_good_output, .ext_clk_valid,
        .thermal_shutdown_in, .thermal_warning_in, .overvoltage_in, .analog_supply_low,
        .pg_invalid, .below_short, .ilim_active, .meas_done, .startup_done, .enable_req,
        .gpo_a_req, .gpo_b_req, .regulator_enable, .general_output_a, .general_output_b,
        .defaults_restore, .serial_reset, .startup_start);
    host_model u_host (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);

    // 200 MHz clock
    always #2.5 clk = ~clk;

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // cycle ceiling well above the ~360 cycles the sequence needs
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            $display("ERROR timeout expected end seen none");
            end_sim;
        end
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // read a register and compare with the model; summaries derived here
    task automatic chk(input logic [7:0] a);
        logic [7:0] e;
        case (a)
            ADDR_TOP_FIRST:  e = 8'(top | (lin != 0 ? 64 : 0) | (buck != 0 ? 32 : 0));
            ADDR_TOP_SECOND: e = 8'(sec);
            ADDR_BUCK:       e = 8'(buck);
            ADDR_LINEAR:     e = 8'(lin);
            ADDR_LIVE:       e = {power_good_output, 2'b00, ~ext_clk_valid,
                                  thermal_shutdown_in, thermal_warning_in, overvoltage_in, 1'b0};
            default:         e = 8'h00;
        endcase
        u_host.rd(a, rdv);
        cmp($sformatf("reg %h", a), e, rdv);
    endtask
    task automatic clr(input logic [7:0] a, input logic [7:0] d);
        u_host.wr(a, d);
        top  &= (a == ADDR_TOP_FIRST)  ? ~int'(d) : -1;
        sec  &= (a == ADDR_TOP_SECOND) ? ~int'(d) : -1;
        buck &= (a == ADDR_BUCK)       ? ~int'(d) : -1;
        lin  &= (a == ADDR_LINEAR)     ? ~int'(d) : -1;
    endtask
    // bounded wait for a one-cycle pulse
    task automatic wpulse(input bit st);
        int n;
        n = 0;
        while ((st ? startup_start : defaults_restore) !== 1'b1 && n < 40)
        begin
            wt(1);
            n++;
        end
        cmp(st ? "startup pulse" : "restore pulse", 8'd1, 8'(n < 40));
    endtask
    task automatic fault(input int k);
        thermal_shutdown_in = (k == 0);
        overvoltage_in      = (k == 1);
        wt(1);
        clr(ADDR_TOP_FIRST, 8'h0a);
        top |= (k == 0) ? 8 : 2;
        chk(ADDR_TOP_FIRST);
        cmp("enable", 8'h00, 8'(regulator_enable));
        cmp("outputs", 8'h00, 8'({general_output_a, general_output_b}));
        thermal_shutdown_in = 1'b0;
        overvoltage_in      = 1'b0;
        enable_req          = 4'($random(seed)) | 4'h1;
        wt(4);
        cmp("enable held off", 8'h00, 8'(regulator_enable));
        clr(ADDR_TOP_FIRST, (k == 0) ? 8'h08 : 8'h02);
        wt(3);
        cmp("enable back", 8'(enable_req), 8'(regulator_enable));
        cmp("outputs back", 8'h03, 8'({general_output_a, general_output_b}));
    endtask

    // main sequence
    initial
    begin
        {clk, nrst, power_good_output, ext_clk_valid, thermal_shutdown_in} = '0;
        {thermal_warning_in, overvoltage_in, analog_supply_low, meas_done, startup_done} = '0;
        {pg_invalid, below_short, ilim_active} = '0;
        {top, sec, buck, lin, n_fail, check_count, cyc} = '0;
        seed       = 32'h9d8dc63e;
        enable_req = 4'($random(seed));
        gpo_a_req  = 1'b1;
        gpo_b_req  = 1'b1;
        ce         = 1'b1;
        wt(8);
        nrst = 1'b1;
        wt(4);
        for (int a = 8'h18; a <= 8'h1e; a++)
            chk(8'(a));
        meas_done = 1'b1;
        wt(1);
        meas_done = 1'b0;
        top |= 1;
        chk(ADDR_TOP_FIRST);
        clr(ADDR_TOP_FIRST, 8'hff);
        chk(ADDR_TOP_FIRST);
        power_good_output = 1'b1;
        wt(4);
        chk(ADDR_LIVE);
        power_good_output = 1'b0;
        wt(4);
        top |= 128;
        chk(ADDR_TOP_FIRST);
        clr(ADDR_TOP_FIRST, 8'h80);
        for (int i = 0; i < 2; i++)
        begin
            ext_clk_valid = !ext_clk_valid;
            wt(4);
            top |= 16;
            chk(ADDR_TOP_FIRST);
            clr(ADDR_TOP_FIRST, 8'h10);
        end
        thermal_warning_in = 1'b1;
        wt(4);
        top |= 4;
        chk(ADDR_TOP_FIRST);
        cmp("enable kept", 8'(enable_req), 8'(regulator_enable));
        thermal_warning_in = 1'b0;
        wt(4);
        chk(ADDR_TOP_FIRST);
        chk(ADDR_LIVE);
        clr(ADDR_TOP_FIRST, 8'h04);
        // a frozen cycle must ignore a same-clock event
        ce        = 1'b0;
        meas_done = 1'b1;
        wt(1);
        {ce, meas_done} = 2'b10;
        chk(ADDR_TOP_FIRST);
        fault(0);
        fault(1);
        for (int ch = 0; ch < NUM_CH; ch++)
        begin
            b = (ch % 2) * GRP_STRIDE;
            ilim_active[ch] = 1'b1;
            wt(4);
            ilim_active[ch] = 1'b0;
            pg_invalid[ch]  = 1'b1;
            below_short[ch] = 1'b1;
            wt(SC / 2);
            below_short[ch] = 1'b0;
            wt(4);
            buck |= (ch < 2) ? (5 << b) : 0;
            lin  |= (ch < 2) ? 0 : (5 << b);
            chk(ADDR_TOP_FIRST);
            chk(ADDR_BUCK);
            chk(ADDR_LINEAR);
            below_short[ch] = 1'b1;
            wt(SC + 8);
            below_short[ch] = 1'b0;
            pg_invalid[ch]  = 1'b0;
            buck |= (ch < 2) ? (2 << b) : 0;
            lin  |= (ch < 2) ? 0 : (2 << b);
            chk((ch < 2) ? ADDR_BUCK : ADDR_LINEAR);
            clr((ch < 2) ? ADDR_BUCK : ADDR_LINEAR, 8'h77);
        end
        chk(ADDR_TOP_FIRST);
        ilim_active[0] = 1'b1;
        wt(4);
        buck |= 1;
        clr(ADDR_BUCK, 8'h01);
        buck |= 1;
        chk(ADDR_BUCK);
        ilim_active[0] = 1'b0;
        wt(3);
        clr(ADDR_BUCK, 8'h01);
        chk(ADDR_BUCK);
        top |= 1;
        meas_done = 1'b1;
        wt(1);
        meas_done = 1'b0;
        for (int k = 0; k < 2; k++)
        begin
            if (k == 0)
                u_host.wr(ADDR_SOFTWARE_RESET_BIT, 8'h01);
            analog_supply_low = (k == 1);
            wpulse(1'b0);
            cmp("serial reset", 8'h01, 8'(serial_reset));
            // enables drop one cycle after the sequencer leaves idle
            wt(1);
            cmp("enable in reset", 8'h00, 8'(regulator_enable));
            analog_supply_low = 1'b0;
            wpulse(1'b1);
            startup_done = 1'b1;
            wt(2);
            startup_done = 1'b0;
            wt(1);
            {top, buck, lin, sec} = {32'd0, 32'd0, 32'd0, 32'd1};
            chk(ADDR_TOP_FIRST);
            chk(ADDR_TOP_SECOND);
            chk(ADDR_SOFTWARE_RESET_BIT);
            clr(ADDR_TOP_SECOND, 8'h01);
        end
        end_sim;
    end
endmodule // regulator_event_flags_tb_top
